// ### src/utopia_addr_match_select.sv
// Address match, selection and queue-clear sequencing for the parallel host ports
// Behaviour
// R1: Low match input addresses both ports
// R2: Match sampled separately per port clock
// R3: Queue mode: send flags follow sampled match
// R4: Bypass: send flags follow reference-sampled match; with CTRL_BYTEPACK set the code samples the match on the send clock instead
// R5: Receive flags follow receive-clock-sampled match
// R6: Selection and clear sequence never coexist
// R7: Host gives match at or before strobe
// R8: Send addressed/clear-addressed states drive flags
// R9: Send strobe fall selects; writes until high
// R10: Bypass send still needs selection to load
// R11: Bypass, strobe idle: send fill character
// R12: Bypass: match loss keeps data, floats flags
// R13: Fill slots track disparity only when encoding
// R14: Consecutive fill characters alternate disparity
// R15: Receive addressed/clear-addressed states drive flags
// R16: Receive strobe fall selects; reads until high
// R17: Bypass: output character clock, bus when selected
// R18: Bypass receive: strobe after match, hold selection
// R19: Bypass reselect needs new match; bus floats
// R20: Bypass receive flags follow match only
// R21: Cascade model makes flags and strobes active high
// R22: Clear after eight consecutive clear-addressed cycles
// R23: Reset clears states and floats drivers
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module utopia_addr_match_select
#(
  parameter int DATA_W = 12
) (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst_b,
  // AXI4-Lite slave
  input  wire logic [utopia_match_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [utopia_match_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // Host pins
  input  wire logic                                addrMatchInB,
  input  wire logic                                sendHostClock,
  input  wire logic                                referenceClock,
  input  wire logic                                recvHostClockIn,
  output logic                                     recvHostClockOut,
  output logic                                     recvHostClockOe,
  input  wire logic                                sendWriteStrobe,
  input  wire logic                                recvReadStrobe,
  input  wire logic                                sendQueueClearReqB,
  input  wire logic                                recvQueueClearReqB,
  input  wire logic [DATA_W-1:0]                   sendParallelBus,
  output logic [DATA_W-1:0]                        recvParallelBus,
  output logic                                     recvParallelBusOe,
  output logic                                     sendQueueFullFlag,
  output logic                                     sendQueueEmptyFlag,
  output logic                                     sendFlagsOe,
  output logic                                     recvQueueFullFlag,
  output logic                                     recvQueueEmptyFlag,
  output logic                                     recvFlagsOe,
  // Queue side
  input  wire logic                                sendQueueFull,
  input  wire logic                                sendQueueEmpty,
  input  wire logic                                recvQueueFull,
  input  wire logic                                recvQueueEmpty,
  output logic                                     sendQueueWrite,
  output logic [DATA_W-1:0]                        sendQueueData,
  output logic                                     sendQueueClear,
  output logic                                     recvQueueRead,
  input  wire logic [DATA_W-1:0]                   recvQueueData,
  output logic                                     recvQueueClear,
  // Serializer side
  input  wire logic                                recvCharTick,
  output logic                                     txCharValid,
  output logic [DATA_W-1:0]                        txChar,
  output logic                                     txCharIsFill,
  output logic                                     txFillNegDisp
);
  import utopia_match_pkg::*;

  typedef struct packed {
    logic [NUM_PINS-1:0] sA;
    logic [NUM_PINS-1:0] sB;
    logic [NUM_PINS-1:0] sC;
    logic [NUM_PINS-1:0] filt;
    logic [DATA_W-1:0]   dA;
    logic [DATA_W-1:0]   dB;
    logic [DATA_W-1:0]   dC;
    logic                send_port_address;
    logic                txClrAddr;
    logic                txSel;
    logic                txStbPrev;
    logic [3:0]          txCnt;
    logic                txFlagOe;
    logic                qWr;
    logic [DATA_W-1:0]   qWrData;
    logic                txClr;
    logic                chVld;
    logic [DATA_W-1:0]   chData;
    logic                chFill;
    logic                fillRd;
    logic                recv_port_address;
    logic                rxClrAddr;
    logic                rxSel;
    logic                rxStbPrev;
    logic                rxAmPrev;
    logic [3:0]          rxCnt;
    logic                rxFlagOe;
    logic                rxRd;
    logic                rxClr;
    logic                rxClkOut;
    logic [DATA_W-1:0]   recv_parallel_bus;
    logic [3:0]          flags;
    logic [3:0]          ctrl;
    logic                awHeld;
    logic [ADDR_W-1:0]   awAddr;
    logic                wHeld;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                bValid;
    logic [1:0]          bResp;
    logic                rValid;
    logic [1:0]          rResp;
    logic [31:0]         rData;
  } state_t;

  state_t q;
  state_t n;

  // Next clear count: saturates, holds while the strobe blocks it
  function automatic logic [3:0] clearCount(input logic clrAddr, input logic stb, input logic [3:0] cnt);
    if (!clrAddr) begin
      clearCount = 4'h0;
    end else if (stb || cnt == CLEAR_HOLD_CYCLES) begin
      clearCount = cnt;
    end else begin
      clearCount = cnt + 4'h1;
    end
  endfunction

  // Flag level towards the pin
  function automatic logic flagLevel(input logic active, input logic cascade);
    flagLevel = cascade ? active : ~active;
  endfunction

  logic bypass;
  logic cascade;
  logic amLow;
  logic txEdge;
  logic rxEdge;
  logic sStb;
  logic rStb;
  logic sClrLow;
  logic rClrLow;
  logic [31:0] status;

  always_comb begin
    n = q;
    n.qWr = 1'b0;
    n.txClr = 1'b0;
    n.chVld = 1'b0;
    n.rxRd = 1'b0;
    n.rxClr = 1'b0;
    // ==========================================================
    // Pin synchronisers: a change counts once stages two and three agree
    n.sA = {recvQueueClearReqB, sendQueueClearReqB, recvReadStrobe, sendWriteStrobe,
            referenceClock, recvHostClockIn, sendHostClock, addrMatchInB};
    n.sB = q.sA;
    n.sC = q.sB;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (q.sB[i] == q.sC[i]) begin
        n.filt[i] = q.sC[i];
      end
    end
    // Data follows the same depth as its strobe
    n.dA = sendParallelBus;
    n.dB = q.dA;
    n.dC = q.dB;
    bypass  = q.ctrl[CTRL_BYPASS];
    cascade = q.ctrl[CTRL_CASCADE];
    amLow   = ~n.filt[PIN_AM];                                                 // [R1]
    sStb    = cascade ? n.filt[PIN_SSTB] : ~n.filt[PIN_SSTB];                  // [R21]
    rStb    = cascade ? n.filt[PIN_RSTB] : ~n.filt[PIN_RSTB];                  // [R21]
    sClrLow = ~n.filt[PIN_SCLR];
    rClrLow = ~n.filt[PIN_RCLR];
    // Each side samples the match input on its own clock
    txEdge = (bypass && !q.ctrl[CTRL_BYTEPACK]) ? (n.filt[PIN_REF] & ~q.filt[PIN_REF])
                                                : (n.filt[PIN_SCLK] & ~q.filt[PIN_SCLK]); // [R2] [R4]
    rxEdge = bypass ? recvCharTick : (n.filt[PIN_RCLK] & ~q.filt[PIN_RCLK]);  // [R2] [R17]
    n.flags = {flagLevel(recvQueueEmpty, cascade), flagLevel(recvQueueFull, cascade),
               flagLevel(sendQueueEmpty, cascade), flagLevel(sendQueueFull, cascade)}; // [R21]
    // ==========================================================
    // Send side
    if (txEdge) begin
      n.txStbPrev = sStb;
      // Clear match is refused while selected, so both never coexist
      n.send_port_address    = amLow && !sClrLow;                                         // [R8]
      n.txClrAddr = amLow && sClrLow && !q.txSel;                              // [R6] [R8]
      n.txFlagOe  = bypass ? amLow : (n.send_port_address || n.txClrAddr);                // [R3] [R4] [R12]
      if (q.txSel) begin
        n.txSel = sStb;
      end else begin
        n.txSel = n.send_port_address && sStb && !q.txStbPrev;                            // [R7] [R9] [R10]
      end
      n.txCnt = clearCount(n.txClrAddr, sStb, q.txCnt);
      n.txClr = (n.txCnt == CLEAR_HOLD_CYCLES) && (q.txCnt != CLEAR_HOLD_CYCLES); // [R22]
      if (bypass) begin
        n.chVld = 1'b1;
        if (n.txSel) begin
          n.chData = q.dC;                                                     // [R10] [R12]
          n.chFill = 1'b0;
        end else begin
          n.chData = DATA_W'(SYNC_FILL_CHAR);                                  // [R11] [R13]
          n.chFill = 1'b1;
          // Without the encoder the fill carries no running disparity
          n.fillRd = q.ctrl[CTRL_ENCODER] ? ~q.fillRd : 1'b0;                  // [R13] [R14]
        end
      end else if (n.txSel) begin
        n.qWr     = 1'b1;                                                      // [R9]
        n.qWrData = q.dC;
      end
    end
    // ==========================================================
    // Receive side
    if (rxEdge) begin
      n.rxStbPrev = rStb;
      n.rxAmPrev  = amLow;
      n.recv_port_address    = amLow && !rClrLow;                                         // [R15]
      n.rxClrAddr = amLow && rClrLow && !q.rxSel;                              // [R6] [R15]
      n.rxFlagOe  = bypass ? amLow : (n.recv_port_address || n.rxClrAddr);                // [R5] [R20]
      if (q.rxSel) begin
        n.rxSel = rStb;                                                        // [R16] [R18]
      end else if (bypass) begin
        // Match must precede the strobe by a cycle and the strobe be fresh
        n.rxSel = q.rxAmPrev && !rClrLow && rStb && !q.rxStbPrev;             // [R18] [R19]
      end else begin
        n.rxSel = n.recv_port_address && rStb && !q.rxStbPrev;                            // [R7] [R16]
      end
      n.rxCnt = clearCount(n.rxClrAddr, rStb, q.rxCnt);
      n.rxClr = (n.rxCnt == CLEAR_HOLD_CYCLES) && (q.rxCnt != CLEAR_HOLD_CYCLES); // [R22]
      if (n.rxSel) begin
        n.rxRd   = !bypass;                                                    // [R16]
        n.recv_parallel_bus = recvQueueData;
      end
    end
    n.rxClkOut = bypass && recvCharTick;                                       // [R17]
    // ==========================================================
    // Register bus
    status = '0;
    status[5:0] = {q.rxSel, q.rxClrAddr, q.recv_port_address, q.txSel, q.txClrAddr, q.send_port_address};
    status[6] = q.fillRd;
    status[ST_TX_CNT +: 4] = q.txCnt;
    status[ST_RX_CNT +: 4] = q.rxCnt;
    if (s_axi_awvalid && !q.awHeld) begin
      n.awHeld = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wHeld) begin
      n.wHeld = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
    end
    if (q.awHeld && q.wHeld && !q.bValid) begin
      n.awHeld = 1'b0;
      n.wHeld  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = RESP_OKAY;
      if (q.awAddr == REG_CTRL_OFS) begin
        if (q.wStrb[0]) begin
          n.ctrl = q.wData[3:0];
        end
      end else if (q.awAddr != REG_STATUS_OFS) begin
        n.bResp = RESP_SLVERR;
      end
    end
    if (q.bValid && s_axi_bready) begin
      n.bValid = 1'b0;
    end
    if (s_axi_arvalid && !q.rValid) begin
      n.rValid = 1'b1;
      n.rResp  = RESP_OKAY;
      n.rData  = '0;
      if (s_axi_araddr == REG_CTRL_OFS) begin
        n.rData[3:0] = q.ctrl;
      end else if (s_axi_araddr == REG_STATUS_OFS) begin
        n.rData = status;
      end else begin
        n.rResp = RESP_SLVERR;
      end
    end else if (q.rValid && s_axi_rready) begin
      n.rValid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;                                                                 // [R23]
      q.sA <= '1;
      q.sB <= '1;
      q.sC <= '1;
      q.filt <= '1;
      q.flags <= '1;
      q.ctrl <= CTRL_RESET;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready      = !q.awHeld;
  assign s_axi_wready       = !q.wHeld;
  assign s_axi_bvalid       = q.bValid;
  assign s_axi_bresp        = q.bResp;
  assign s_axi_arready      = !q.rValid;
  assign s_axi_rvalid       = q.rValid;
  assign s_axi_rdata        = q.rData;
  assign s_axi_rresp        = q.rResp;
  assign sendFlagsOe        = q.txFlagOe;
  assign recvFlagsOe        = q.rxFlagOe;
  assign sendQueueFullFlag  = q.flags[0];
  assign sendQueueEmptyFlag = q.flags[1];
  assign recvQueueFullFlag  = q.flags[2];
  assign recvQueueEmptyFlag = q.flags[3];
  assign recvParallelBus    = q.recv_parallel_bus;
  assign recvParallelBusOe  = q.rxSel;                                         // [R17] [R19]
  assign recvHostClockOut   = q.rxClkOut;
  assign recvHostClockOe    = q.ctrl[CTRL_BYPASS];
  assign sendQueueWrite     = q.qWr;
  assign sendQueueData      = q.qWrData;
  assign sendQueueClear     = q.txClr;
  assign recvQueueRead      = q.rxRd;
  assign recvQueueClear     = q.rxClr;
  assign txCharValid        = q.chVld;
  assign txChar             = q.chData;
  assign txCharIsFill       = q.chFill;
  assign txFillNegDisp      = q.fillRd;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  tx_mutual_excl_a: assert property (!(q.txSel && q.txClrAddr))               // [R6]
    else $error("send selection and clear overlap");
  rx_mutual_excl_a: assert property (!(q.rxSel && q.rxClrAddr))               // [R6]
    else $error("receive selection and clear overlap");
  tx_flag_oe_a: assert property (!q.ctrl[CTRL_BYPASS] && q.txFlagOe |-> q.send_port_address || q.txClrAddr) // [R3]
    else $error("send flags driven without address");
  rx_flag_oe_a: assert property (!q.ctrl[CTRL_BYPASS] && q.rxFlagOe |-> q.recv_port_address || q.rxClrAddr) // [R15]
    else $error("receive flags driven without address");
  clear_count_a: assert property (q.txClr |-> q.txClrAddr && q.txCnt == CLEAR_HOLD_CYCLES // [R22]
    && $past(q.txCnt) != CLEAR_HOLD_CYCLES)
    else $error("send clear without eight cycles");
  rx_clear_count_a: assert property ($rose(q.rxClr) |-> q.rxCnt == CLEAR_HOLD_CYCLES) // [R22]
    else $error("receive clear early");
  queue_write_sel_a: assert property (q.qWr |-> q.txSel && !q.ctrl[CTRL_BYPASS]) // [R9]
    else $error("queue write while unselected");
  fill_on_idle_a: assert property (q.chVld && !q.txSel |-> q.chFill)          // [R11]
    else $error("data sent without selection");
  fill_disparity_a: assert property (q.chVld && q.chFill                    // [R13] [R14]
    |-> q.fillRd == ($past(q.ctrl[CTRL_ENCODER]) ? !$past(q.fillRd) : 1'b0))
    else $error("fill disparity not alternating");
  bus_oe_sel_a: assert property (!q.rxSel |-> !recvParallelBusOe && !q.rxRd) // [R19]
    else $error("receive bus driven unselected");
endmodule // utopia_addr_match_select

// ### src/utopia_match_pkg.sv
// Constants shared by the address-match and selection block
package utopia_match_pkg;
  // ==========================================================
  // Pin synchroniser slots
  localparam int PIN_AM    = 0;
  localparam int PIN_SCLK  = 1;
  localparam int PIN_RCLK  = 2;
  localparam int PIN_REF   = 3;
  localparam int PIN_SSTB  = 4;
  localparam int PIN_RSTB  = 5;
  localparam int PIN_SCLR  = 6;
  localparam int PIN_RCLR  = 7;
  localparam int NUM_PINS  = 8;
  // ==========================================================
  // Counts and characters
  localparam logic [3:0]  CLEAR_HOLD_CYCLES = 4'h8;
  localparam logic [11:0] SYNC_FILL_CHAR    = 12'h0BC;
  // ==========================================================
  // Register map
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  REG_CTRL_OFS   = 4'h0;
  localparam logic [3:0]  REG_STATUS_OFS = 4'h4;
  localparam int          CTRL_BYPASS    = 0;
  localparam int          CTRL_CASCADE   = 1;
  localparam int          CTRL_BYTEPACK  = 2;
  localparam int          CTRL_ENCODER   = 3;
  localparam logic [3:0]  CTRL_RESET     = 4'h8;
  localparam int          ST_TX_CNT      = 8;
  localparam int          ST_RX_CNT      = 12;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ### verif/host_atm_model.sv
// Host controller model driving match, strobes, clears and send data
`timescale 1ns/1ps
module host_atm_model (
  // Host clock and pins
  output logic        hostClk,
  output logic        addrMatchInB,
  output logic        sendWriteStrobe,
  output logic        recvReadStrobe,
  output logic        sendQueueClearReqB,
  output logic        recvQueueClearReqB,
  output logic [11:0] sendParallelBus
);
  // ==========================================================
  // Idle levels and free-running host clock
  initial begin
    hostClk = 1'b0;
    addrMatchInB = 1'b1;
    sendWriteStrobe = 1'b1;
    recvReadStrobe = 1'b1;
    sendQueueClearReqB = 1'b1;
    recvQueueClearReqB = 1'b1;
    sendParallelBus = 12'h000;
    forever #160 hostClk = ~hostClk;
  end
  // ==========================================================
  // Pins change between host edges, so each call meets exactly one sampling edge
  task automatic step(input logic am, input logic ws, input logic rs, input logic sc, input logic rc,
                      input logic [11:0] d, input logic drv);
    addrMatchInB <= am;
    sendWriteStrobe <= ws;
    recvReadStrobe <= rs;
    sendQueueClearReqB <= sc;
    recvQueueClearReqB <= rc;
    // Released bus toggles so a stale word never looks valid
    sendParallelBus <= drv ? d : ~sendParallelBus;
    @(posedge hostClk);
    // Response settled and counted; next pins go out on a core edge well before the next host edge
    #220;
  endtask
endmodule // host_atm_model

// ### verif/utopia_addr_match_select_tb.sv
// Self-checking bench for address match and port selection
`timescale 1ns/1ps
module utopia_addr_match_select_tb;
  import utopia_match_pkg::*;
  // ==========================================================
  // Signals
  logic        core_clk, rst_b, recvCharTick, hostClk, amB, sStb, rStb, sClrB, rClrB, sqFull, encOn;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, prevFill, prevNeg;
  logic        busOe, sFull, sOe, rOe, sqWr, sqClr, rqRd, rqClr, rcOut, rcOe, txValid, txFill, txNeg, rEmpty;
  logic [3:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_rresp, s_axi_bresp, rr;
  logic [11:0] sendBus, recvBus, qData, txChar, lastWr, lastTx;
  int          badCount, nTests, wrCnt, rdCnt, sClrCnt, rClrCnt, fillCnt, fillBad, dispBad, rcoCnt, tick, w0;

  host_atm_model host_atm_model_inst (
    .hostClk(hostClk), .addrMatchInB(amB), .sendWriteStrobe(sStb), .recvReadStrobe(rStb),
    .sendQueueClearReqB(sClrB), .recvQueueClearReqB(rClrB), .sendParallelBus(sendBus)
  );
  utopia_addr_match_select utopia_addr_match_select_inst (
    .core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .addrMatchInB(amB), .sendHostClock(hostClk), .referenceClock(hostClk), .recvHostClockIn(hostClk),
    .recvHostClockOut(rcOut), .recvHostClockOe(rcOe), .sendWriteStrobe(sStb), .recvReadStrobe(rStb),
    .sendQueueClearReqB(sClrB), .recvQueueClearReqB(rClrB), .sendParallelBus(sendBus),
    .recvParallelBus(recvBus), .recvParallelBusOe(busOe), .sendQueueFullFlag(sFull), .sendQueueEmptyFlag(),
    .sendFlagsOe(sOe), .recvQueueFullFlag(), .recvQueueEmptyFlag(rEmpty), .recvFlagsOe(rOe),
    .sendQueueFull(sqFull), .sendQueueEmpty(1'b0), .recvQueueFull(1'b0), .recvQueueEmpty(1'b0),
    .sendQueueWrite(sqWr), .sendQueueData(qData), .sendQueueClear(sqClr), .recvQueueRead(rqRd),
    .recvQueueData(12'h5A3), .recvQueueClear(rqClr), .recvCharTick(recvCharTick), .txCharValid(txValid),
    .txChar(txChar), .txCharIsFill(txFill), .txFillNegDisp(txNeg)
  );
  // ==========================================================
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================================
  // Pulse counters, character tick and fill watch
  always @(posedge core_clk) begin
    tick = (tick + 1) % 8;
    recvCharTick <= (tick == 0);
    if (sqWr) begin
      wrCnt++;
      lastWr = qData;
    end
    rdCnt += rqRd;
    sClrCnt += sqClr;
    rClrCnt += rqClr;
    rcoCnt += rcOut;
    if (txValid && !txFill) lastTx = txChar;
    if (txValid && txFill) begin
      fillCnt++;
      if (txChar !== SYNC_FILL_CHAR) fillBad++;
      if (encOn ? (prevFill && txNeg === prevNeg) : txNeg !== 1'b0) dispBad++;
    end
    if (txValid) begin
      prevFill = txFill;
      prevNeg = txNeg;
    end
  end
  // ==========================================================
  // Bus tasks and compare
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge core_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [3:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Pins packed as match, send strobe, receive strobe, send clear, receive clear
  task automatic st(input logic [4:0] p, input logic [11:0] d);
    host_atm_model_inst.step(p[4], p[3], p[2], p[1], p[0], d, d != 12'h000);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      badCount++;
    end
  endtask
  task automatic giveVerdict;
    if (badCount == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog, far beyond the expected run
  initial begin
    #300000;
    badCount++;
    giveVerdict();
  end
  // ==========================================================
  // Tests
  initial begin
    rst_b = 1'b0;
    recvCharTick = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    sqFull = 1'b1;
    encOn = 1'b1;
    prevFill = 1'b0;
    prevNeg = 1'b0;
    repeat (19) @(posedge core_clk);
    chk("sendFlagsOe", 32'h0, sOe);
    chk("recvBusOe", 32'h0, busOe);
    @(posedge core_clk);
    rst_b <= 1'b1;
    axiRead(REG_CTRL_OFS);
    chk("ctrl", {28'h0, CTRL_RESET}, rd);
    axiRead(4'h8);
    chk("unmappedResp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    st(5'b10011, 12'h111);
    chk("writes", 32'h0, wrCnt);
    st(5'b11111, 12'h000);
    st(5'b01111, 12'h000);
    chk("sendFlagsOe", 32'h1, sOe);
    chk("recvFlagsOe", 32'h1, rOe);
    chk("sendFullFlag", 32'h0, sFull);
    chk("recvEmptyFlag", 32'h1, rEmpty);
    axiRead(REG_STATUS_OFS);
    chk("status", 32'h09, rd & 32'h3F);
    st(5'b00011, 12'hA5C);
    chk("recvBusOe", 32'h1, busOe);
    chk("recvBus", 32'h5A3, recvBus);
    st(5'b00011, 12'h3C7);
    st(5'b01111, 12'h000);
    chk("writes", 32'h2, wrCnt);
    chk("lastWrite", 32'h3C7, lastWr);
    chk("reads", 32'h2, rdCnt);
    chk("recvBusOe", 32'h0, busOe);
    st(5'b11111, 12'h000);
    chk("sendFlagsOe", 32'h0, sOe);
    repeat (8) st(5'b01100, 12'h000);
    chk("sendClears", 32'h1, sClrCnt);
    chk("recvClears", 32'h1, rClrCnt);
    chk("sendFlagsOe", 32'h1, sOe);
    chk("recvFlagsOe", 32'h1, rOe);
    axiRead(REG_STATUS_OFS);
    chk("status", 32'h12, rd & 32'h3F);
    st(5'b11111, 12'h000);
    repeat (7) st(5'b01100, 12'h000);
    st(5'b01111, 12'h000);
    chk("sendClears", 32'h1, sClrCnt);
    st(5'b00011, 12'h123);
    repeat (9) st(5'b00000, 12'h123);
    st(5'b01111, 12'h000);
    chk("sendClears", 32'h1, sClrCnt);
    chk("recvClears", 32'h1, rClrCnt);
    axiWrite(REG_CTRL_OFS, 32'h9);
    chk("writeResp", {30'h0, RESP_OKAY}, {30'h0, rr});
    st(5'b11111, 12'h000);
    st(5'b01111, 12'h000);
    chk("sendFlagsOe", 32'h1, sOe);
    chk("recvFlagsOe", 32'h1, rOe);
    chk("fillSeen", 32'h1, fillCnt > 0);
    st(5'b00011, 12'h2B4);
    chk("recvBusOe", 32'h1, busOe);
    chk("sentChar", 32'h2B4, lastTx);
    st(5'b10011, 12'h2B5);
    chk("sendFlagsOe", 32'h0, sOe);
    chk("recvFlagsOe", 32'h0, rOe);
    chk("recvBusOe", 32'h1, busOe);
    chk("sentChar", 32'h2B5, lastTx);
    st(5'b11111, 12'h000);
    st(5'b11011, 12'h000);
    chk("recvBusOe", 32'h0, busOe);
    chk("fillChar", 32'h0, fillBad);
    chk("fillDisp", 32'h0, dispBad);
    chk("charClock", 32'h1, rcoCnt > 0);
    chk("charClockOe", 32'h1, rcOe);
    axiWrite(REG_CTRL_OFS, 32'h1);
    encOn = 1'b0;
    st(5'b11111, 12'h000);
    dispBad = 0;
    st(5'b11111, 12'h000);
    chk("fillDispOff", 32'h0, dispBad);
    axiWrite(REG_CTRL_OFS, 32'hA);
    sqFull <= 1'b0;
    st(5'b00011, 12'h000);
    chk("sendFullFlag", 32'h0, sFull);
    chk("recvEmptyFlag", 32'h0, rEmpty);
    w0 = wrCnt;
    st(5'b01111, 12'h0F0);
    st(5'b00011, 12'h000);
    chk("writes", 32'h1, wrCnt - w0);
    chk("lastWrite", 32'h0F0, lastWr);
    giveVerdict();
  end
endmodule // utopia_addr_match_select_tb
